// [inc/afe_spi_cfg.svh]
// constants for the converter front-end serial register port
`ifndef AFE_SPI_CFG_SVH
`define AFE_SPI_CFG_SVH

// control byte layout: id, register index, read flag
`define CTRL_ID_MSB      7
`define CTRL_ID_LSB      6
`define CTRL_ADDR_MSB    5
`define CTRL_ADDR_LSB    1
`define CTRL_RW_BIT      0
`define CTRL_RW_READ     1'b1

// bit counter end values
`define CNT_CMD_LAST     6'd7
`define CNT_CRC_LAST     6'd15
`define CNT_W16_LAST     6'd15
`define CNT_W24_LAST     6'd23
`define CNT_W32_LAST     6'd31

// address map
`define ADDR_CH_LAST     5'h02
`define ADDR_TYPE0_LAST  5'h07
`define ADDR_RW_FIRST    5'h08
`define ADDR_MOD         5'h08
`define ADDR_STATUS      5'h09
`define ADDR_LOCK        5'h1f
`define IDX_RW_FIRST     8
`define IDX_STATUS       9
`define IDX_LOCK         31

// status_comm_register fields
`define SC_RDLOOP_MSB    23
`define SC_RDLOOP_LSB    22
`define SC_WRLOOP_BIT    21
`define SC_WIDTH_MSB     17
`define SC_WIDTH_LSB     16
`define SC_CRCEN_BIT     15
`define SC_ALERTEN_BIT   14
`define SC_RESET         24'ha10000

// key and checksum field in the last register
`define LOCK_MSB         23
`define LOCK_LSB         16
`define LOCK_KEY         8'ha5
`define LOCK_RESET       24'ha50000

// address loop modes and data widths
`define LOOP_STATIC      2'b00
`define LOOP_GROUP       2'b01
`define LOOP_TYPE        2'b10
`define WIDTH_16         2'b00
`define WIDTH_24         2'b01

// checksum polynomial and seed
`define CRC_POLY         16'h8005
`define CRC_INIT         16'h0000

`endif

// [inc/afe_spi_pkg.sv]
// types shared by the serial register port
package afe_spi_pkg;

    // one-hot frame states
    typedef enum logic [3:0] {
        ST_CMD  = 4'b0001,
        ST_RD   = 4'b0010,
        ST_WR   = 4'b0100,
        ST_IGN  = 4'b1000
    } spi_state_t;

    // channel results from the converter datapath
    typedef struct packed {
        logic [2:0][23:0] res;
    } ch_results_t;

endpackage : afe_spi_pkg

// [rtl/afe_spi_register_port.sv]
// serial register access port of a three-channel converter front end
`timescale 1ns/1ps
`default_nettype none
`include "afe_spi_cfg.svh"

module afe_spi_register_port #(
    parameter logic [1:0] CHIP_ID = 2'b01,
    parameter int         NUM_CH  = 3
) (
    input  wire logic                     clk_in,
    input  wire logic                     rst_in,
    input  wire logic                     sck_in,
    input  wire logic                     cs_n_in,
    input  wire logic                     sdi_in,
    output logic                          sdo_out,
    output logic                          sdo_oe_out,
    input  wire afe_spi_pkg::ch_results_t ch_data_in,
    input  wire logic                     ch_valid_in,
    output logic                          conversion_ready_n_out,
    output logic [15:0]                   config_crc_out
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    generate
        if (NUM_CH < 1 || NUM_CH > 3) begin : g_bad_ch
            $error("channel count must be 1 to 3");
        end
    endgenerate

    // ************************************************************
    // declarations
    // ************************************************************
    afe_spi_pkg::spi_state_t state_r;
    logic [5:0]  bit_cnt_r;
    logic [4:0]  addr_r;
    logic [31:0] rx_r;
    logic [31:0] rx_nxt;
    logic [31:0] tx_r;
    logic [15:0] crc_o_r;
    logic [15:0] crc_o_nxt;
    logic        crc_ph_r;
    logic        spi_rst;
    logic [23:0] cfg_r [`IDX_RW_FIRST:`IDX_LOCK];
    logic [4:0]  wr_addr_r;
    logic        wr_tgl_r;
    logic [23:0] status_w;
    logic [7:0]  lock_w;
    logic [5:0]  wlen_last;
    logic        word_done;
    logic [4:0]  rd_nxt_addr;
    logic [4:0]  wr_nxt_addr;
    logic        seq_end;
    logic        writable;
    logic        wr_fire;
    logic [23:0] wdata;
    logic [4:0]  rd_sel;
    logic [23:0] rd_word;
    logic [23:0] ch_word [0:2];
    logic [23:0] shadow_r [`IDX_STATUS:`IDX_LOCK];
    logic        tgl_s1_r;
    logic        tgl_s2_r;
    logic        tgl_s3_r;
    logic        upd;
    logic [4:0]  scan_addr_r;
    logic [15:0] scan_acc_r;
    logic [15:0] scan_acc_nxt;
    logic [23:0] scan_word;
    logic [15:0] bg_crc_r;
    logic        bg_valid_r;
    logic        alert_r;

    // ************************************************************
    // helper functions
    // ************************************************************
    // one serial checksum step
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
        logic fb;
        fb = c[15] ^ b;
        crc_step = {c[14:0], 1'b0} ^ (fb ? `CRC_POLY : 16'h0000);
    endfunction : crc_step

    // checksum over a whole register word, msb first
    function automatic logic [15:0] crc_word(input logic [15:0] c, input logic [23:0] w);
        logic [15:0] acc;
        acc = c;
        for (int i = 23; i >= 0; i--) begin
            acc = crc_step(acc, w[i]);
        end
        crc_word = acc;
    endfunction : crc_word

    // address advance within the selected register set
    function automatic logic [4:0] next_addr(input logic [4:0] a, input logic [1:0] m);
        case (m)
            `LOOP_STATIC: next_addr = a;
            `LOOP_GROUP:  next_addr = {a[4:2], a[1:0] + 2'd1};
            `LOOP_TYPE: begin
                if (a == `ADDR_TYPE0_LAST) begin
                    next_addr = 5'h00;
                end else if (a == `ADDR_LOCK) begin
                    next_addr = `ADDR_RW_FIRST;
                end else begin
                    next_addr = a + 5'd1;
                end
            end
            default:      next_addr = a + 5'd1;
        endcase
    endfunction : next_addr

    // ************************************************************
    // serial clock domain: decode
    // ************************************************************
    // deselect resets the frame; hard reset too
    assign spi_rst  = cs_n_in | rst_in;
    assign status_w = cfg_r[`IDX_STATUS];
    assign lock_w   = cfg_r[`IDX_LOCK][`LOCK_MSB:`LOCK_LSB];
    assign rx_nxt   = {rx_r[30:0], sdi_in};

    // payload length from the width field
    always_comb begin
        case (status_w[`SC_WIDTH_MSB:`SC_WIDTH_LSB])
            `WIDTH_16: wlen_last = `CNT_W16_LAST;
            `WIDTH_24: wlen_last = `CNT_W24_LAST;
            default:   wlen_last = `CNT_W32_LAST;
        endcase
    end

    // read loop and write loop selection
    assign word_done   = (bit_cnt_r == wlen_last);
    assign rd_nxt_addr = next_addr(addr_r, status_w[`SC_RDLOOP_MSB:`SC_RDLOOP_LSB]);
    assign wr_nxt_addr = next_addr(addr_r,
                                   status_w[`SC_WRLOOP_BIT] ? `LOOP_TYPE : `LOOP_STATIC);
    assign seq_end     = (rd_nxt_addr <= addr_r);
    // only unlocked writable addresses, key always
    assign writable    = (addr_r >= `ADDR_RW_FIRST)
                       && ((addr_r == `ADDR_LOCK) || (lock_w == `LOCK_KEY));
    assign wr_fire     = (state_r == afe_spi_pkg::ST_WR) && word_done && writable;
    assign crc_o_nxt   = crc_step(crc_o_r, tx_r[31]);

    // incoming word aligned to the 24-bit register
    always_comb begin
        case (status_w[`SC_WIDTH_MSB:`SC_WIDTH_LSB])
            `WIDTH_16: wdata = {rx_nxt[15:0], 8'h00};
            `WIDTH_24: wdata = rx_nxt[23:0];
            default:   wdata = rx_nxt[31:8];
        endcase
    end

    // address whose contents load the transmit shifter next
    always_comb begin
        if (state_r == afe_spi_pkg::ST_CMD) begin
            rd_sel = rx_nxt[`CTRL_ADDR_MSB:`CTRL_ADDR_LSB];
        end else if (crc_ph_r) begin
            rd_sel = addr_r;
        end else begin
            rd_sel = rd_nxt_addr;
        end
    end

    // read mux; channel and checksum words are quasi-static
    // they change only around a ready pulse or a config write
    always_comb begin
        rd_word = 24'h000000;
        if (rd_sel <= `ADDR_CH_LAST) begin
            rd_word = ch_word[rd_sel[1:0]];
        end else if (rd_sel == `ADDR_LOCK) begin
            rd_word = {lock_w, bg_crc_r};
        end else if (rd_sel >= `ADDR_RW_FIRST) begin
            rd_word = cfg_r[rd_sel];
        end
    end

    // ************************************************************
    // serial clock domain: frame sequencer
    // ************************************************************
    // input sampled on the rising edge
    always_ff @(posedge sck_in or posedge spi_rst) begin
        if (spi_rst) begin
            rx_r <= 32'h00000000;
        end else begin
            rx_r <= rx_nxt;
        end
    end

    // control byte, then read, write or ignore
    always_ff @(posedge sck_in or posedge spi_rst) begin
        if (spi_rst) begin
            state_r   <= afe_spi_pkg::ST_CMD;
            bit_cnt_r <= 6'd0;
            addr_r    <= 5'h00;
            tx_r      <= 32'h00000000;
            crc_o_r   <= `CRC_INIT;
            crc_ph_r  <= 1'b0;
        end else begin
            case (state_r)
                afe_spi_pkg::ST_CMD: begin
                    bit_cnt_r <= bit_cnt_r + 6'd1;
                    if (bit_cnt_r == `CNT_CMD_LAST) begin
                        bit_cnt_r <= 6'd0;
                        addr_r    <= rx_nxt[`CTRL_ADDR_MSB:`CTRL_ADDR_LSB];
                        if (rx_nxt[`CTRL_ID_MSB:`CTRL_ID_LSB] != CHIP_ID) begin
                            state_r <= afe_spi_pkg::ST_IGN;
                        end else if (rx_nxt[`CTRL_RW_BIT] == `CTRL_RW_READ) begin
                            state_r <= afe_spi_pkg::ST_RD;
                            tx_r    <= {rd_word, 8'h00};
                        end else begin
                            state_r <= afe_spi_pkg::ST_WR;
                        end
                    end
                end
                // read stream, input not looked at
                afe_spi_pkg::ST_RD: begin
                    tx_r      <= {tx_r[30:0], 1'b0};
                    bit_cnt_r <= bit_cnt_r + 6'd1;
                    if (crc_ph_r) begin
                        if (bit_cnt_r == `CNT_CRC_LAST) begin
                            bit_cnt_r <= 6'd0;
                            crc_ph_r  <= 1'b0;
                            crc_o_r   <= `CRC_INIT;
                            tx_r      <= {rd_word, 8'h00};
                        end
                    end else begin
                        crc_o_r <= crc_o_nxt;
                        if (word_done) begin
                            bit_cnt_r <= 6'd0;
                            addr_r    <= rd_nxt_addr;
                            if (status_w[`SC_CRCEN_BIT] && seq_end) begin
                                crc_ph_r <= 1'b1;
                                tx_r     <= {crc_o_nxt, 16'h0000};
                            end else begin
                                tx_r <= {rd_word, 8'h00};
                            end
                        end
                    end
                end
                afe_spi_pkg::ST_WR: begin
                    bit_cnt_r <= bit_cnt_r + 6'd1;
                    if (word_done) begin
                        bit_cnt_r <= 6'd0;
                        if (writable) begin
                            addr_r <= wr_nxt_addr;
                        end
                    end
                end
                afe_spi_pkg::ST_IGN: begin
                    bit_cnt_r <= 6'd0;
                end
                default: begin
                    state_r <= afe_spi_pkg::ST_IGN;
                end
            endcase
        end
    end

    // output on the falling edge; driven only in reads
    always_ff @(negedge sck_in or posedge spi_rst) begin
        if (spi_rst) begin
            sdo_out    <= 1'b0;
            sdo_oe_out <= 1'b0;
        end else begin
            sdo_out    <= tx_r[31];
            sdo_oe_out <= (state_r == afe_spi_pkg::ST_RD);
        end
    end

    // register file, kept across frames, cleared only by hard reset
    always_ff @(posedge sck_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = `IDX_RW_FIRST; i <= `IDX_LOCK; i++) begin
                cfg_r[i] <= 24'h000000;
            end
            cfg_r[`IDX_STATUS] <= `SC_RESET;
            cfg_r[`IDX_LOCK]   <= `LOCK_RESET;
            wr_addr_r          <= 5'h00;
            wr_tgl_r           <= 1'b0;
        end else if (wr_fire) begin
            cfg_r[addr_r] <= wdata;
            wr_addr_r     <= addr_r;
            // toggle announces the word; it stays put for the sync
            wr_tgl_r      <= ~wr_tgl_r;
        end
    end

    // ************************************************************
    // master clock domain: write crossing
    // ************************************************************
    // two-stage toggle synchroniser, edge seen past the second stage
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tgl_s1_r <= 1'b0;
            tgl_s2_r <= 1'b0;
            tgl_s3_r <= 1'b0;
        end else begin
            tgl_s1_r <= wr_tgl_r;
            tgl_s2_r <= tgl_s1_r;
            tgl_s3_r <= tgl_s2_r;
        end
    end
    assign upd = tgl_s2_r ^ tgl_s3_r;

    // configuration copy; modulator output word is not kept here
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = `IDX_STATUS; i <= `IDX_LOCK; i++) begin
                shadow_r[i] <= 24'h000000;
            end
            shadow_r[`IDX_STATUS] <= `SC_RESET;
            shadow_r[`IDX_LOCK]   <= `LOCK_RESET;
        end else if (upd && (wr_addr_r != `ADDR_MOD)) begin
            shadow_r[wr_addr_r] <= cfg_r[wr_addr_r];
        end
    end

    // ************************************************************
    // master clock domain: background checksum
    // ************************************************************
    // checksum field itself is left out so it cannot feed back
    assign scan_word    = (scan_addr_r == `ADDR_LOCK)
                        ? {shadow_r[`IDX_LOCK][`LOCK_MSB:`LOCK_LSB], 16'h0000}
                        : shadow_r[scan_addr_r];
    assign scan_acc_nxt = crc_word(scan_acc_r, scan_word);

    // one register per cycle, result published per pass
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            scan_addr_r <= `ADDR_STATUS;
            scan_acc_r  <= `CRC_INIT;
            bg_crc_r    <= `CRC_INIT;
            bg_valid_r  <= 1'b0;
        end else if (scan_addr_r == `ADDR_LOCK) begin
            scan_addr_r <= `ADDR_STATUS;
            scan_acc_r  <= `CRC_INIT;
            bg_crc_r    <= scan_acc_nxt;
            bg_valid_r  <= 1'b1;
        end else begin
            scan_addr_r <= scan_addr_r + 5'd1;
            scan_acc_r  <= scan_acc_nxt;
        end
    end
    assign config_crc_out = bg_crc_r;

    // sticky alert while enabled; first pass after reset only seeds
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            alert_r <= 1'b0;
        end else if (!shadow_r[`IDX_STATUS][`SC_ALERTEN_BIT]) begin
            alert_r <= 1'b0;
        end else if ((scan_addr_r == `ADDR_LOCK) && bg_valid_r
                     && (scan_acc_nxt != bg_crc_r)) begin
            alert_r <= 1'b1;
        end
    end

    // ************************************************************
    // master clock domain: channel results and ready pin
    // ************************************************************
    // per-channel result latch on each new conversion
    generate
        for (genvar g = 0; g < 3; g++) begin : g_ch
            if (g < NUM_CH) begin : g_on
                logic [23:0] res_r;
                always_ff @(posedge clk_in or posedge rst_in) begin
                    if (rst_in) begin
                        res_r <= 24'h000000;
                    end else if (ch_valid_in) begin
                        res_r <= ch_data_in.res[g];
                    end
                end
                assign ch_word[g] = res_r;
            end else begin : g_off
                assign ch_word[g] = 24'h000000;
            end
        end
    endgenerate

    // one-cycle low pulse per result; alert holds it low
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            conversion_ready_n_out <= 1'b1;
        end else begin
            conversion_ready_n_out <= ~(ch_valid_in | alert_r);
        end
    end

endmodule : afe_spi_register_port

`default_nettype wire

// [verif/afe_spi_register_port_checker.sv]
// assertion checker for the serial register port
`timescale 1ns/1ps
`default_nettype none
module afe_spi_register_port_checker #(
    parameter logic [1:0] CHIP_ID = 2'b01
) (
    input wire logic                     clk_in,
    input wire logic                     rst_in,
    input wire logic                     sck_in,
    input wire logic                     cs_n_in,
    input wire logic                     sdi_in,
    input wire logic                     sdo_out,
    input wire logic                     sdo_oe_out,
    input wire afe_spi_pkg::ch_results_t ch_data_in,
    input wire logic                     ch_valid_in,
    input wire logic                     conversion_ready_n_out,
    input wire logic [15:0]              config_crc_out
);
    // ****
    // frame tracking
    // ****
    logic [3:0] cnt_r;
    logic [7:0] ctl_r;
    // control byte capture, cleared on deselect like the port
    always_ff @(posedge sck_in or posedge cs_n_in or posedge rst_in) begin
        if (cs_n_in || rst_in) begin
            cnt_r <= 4'h0;
            ctl_r <= 8'h00;
        end else if (cnt_r < 4'h8) begin
            cnt_r <= cnt_r + 4'h1;
            ctl_r <= {ctl_r[6:0], sdi_in};
        end
    end
    // ****
    // properties
    // ****
    sequence s_pulse;
        !conversion_ready_n_out ##1 conversion_ready_n_out;
    endsequence
    property p_rdy_pulse;
        @(posedge clk_in) disable iff (rst_in) ch_valid_in |-> ##1 s_pulse;
    endproperty
    property p_oe_cs;
        @(posedge clk_in) disable iff (rst_in) cs_n_in |-> !sdo_oe_out;
    endproperty
    property p_rst_out;
        @(posedge clk_in) rst_in |-> conversion_ready_n_out && !sdo_oe_out
            && config_crc_out == 16'h0000;
    endproperty
    property p_cmd_quiet;
        @(posedge sck_in) disable iff (rst_in || cs_n_in) cnt_r < 4'h8 |-> !sdo_oe_out;
    endproperty
    property p_wr_quiet;
        @(posedge sck_in) disable iff (rst_in || cs_n_in)
            cnt_r == 4'h8 && !ctl_r[0] |-> !sdo_oe_out;
    endproperty
    property p_foreign;
        @(posedge sck_in) disable iff (rst_in || cs_n_in)
            cnt_r == 4'h8 && ctl_r[7:6] != CHIP_ID |-> !sdo_oe_out;
    endproperty
    property p_rd_oe;
        @(posedge sck_in) disable iff (rst_in || cs_n_in)
            cnt_r == 4'h8 && ctl_r[0] && ctl_r[7:6] == CHIP_ID |-> sdo_oe_out;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse)
        else $error("ready pulse wrong");
    a_oe_cs: assert property (p_oe_cs)
        else $error("output driven while deselected");
    a_rst_out: assert property (p_rst_out)
        else $error("outputs not at reset values");
    a_cmd_quiet: assert property (p_cmd_quiet)
        else $error("output driven in control byte");
    a_wr_quiet: assert property (p_wr_quiet)
        else $error("output driven in write");
    a_foreign: assert property (p_foreign)
        else $error("output driven for foreign id");
    a_rd_oe: assert property (p_rd_oe)
        else $error("read data not driven");
endmodule : afe_spi_register_port_checker
`default_nettype wire

// [verif/afe_spi_register_port_tb_top.sv]
// testbench for the serial register port
`timescale 1ns/1ps
`default_nettype none
module afe_spi_register_port_tb_top;
    logic                     clk_in = 1'b0;
    logic                     rst_in = 1'b0;
    logic                     ch_valid_in = 1'b0;
    afe_spi_pkg::ch_results_t ch_data_in = '0;
    wire logic                sck_in;
    wire logic                cs_n_in;
    wire logic                sdi_in;
    wire logic                sdo_out;
    wire logic                sdo_oe_out;
    wire logic                conversion_ready_n_out;
    wire logic [15:0]         config_crc_out;
    int                       err_count = 0;
    int                       num_checks = 0;
    logic [63:0]              rx;
    logic [15:0]              c0;
    // 20 MHz master clock
    always #25 clk_in = ~clk_in;
    afe_spi_register_port DUT (.clk_in(clk_in), .rst_in(rst_in), .sck_in(sck_in),
        .cs_n_in(cs_n_in), .sdi_in(sdi_in), .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out),
        .ch_data_in(ch_data_in), .ch_valid_in(ch_valid_in),
        .conversion_ready_n_out(conversion_ready_n_out), .config_crc_out(config_crc_out));
    spi_host_model host (.sck_out(sck_in), .cs_n_out(cs_n_in), .sdi_out(sdi_in),
        .sdo_in(sdo_out), .sdo_oe_in(sdo_oe_out));
    // ****
    // helpers
    // ****
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    function automatic logic [7:0] cb(input logic [4:0] a, input logic rd);
        return {2'b01, a, rd};
    endfunction : cb
    function automatic logic [15:0] crc16(input logic [23:0] d);
        logic [15:0] c;
        c = 16'h0000;
        for (int i = 23; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h8005 : 16'h0000);
        return c;
    endfunction : crc16
    task automatic wr(input logic cpol, input logic [7:0] c, input int n, input logic [47:0] v);
        @(negedge clk_in);
        host.xfer(cpol, 8 + n, (64'(c) << n) | 64'(v), rx);
    endtask : wr
    // sdi held at ones during reads
    task automatic rd(input logic cpol, input logic [4:0] a, input int n);
        @(negedge clk_in);
        host.xfer(cpol, 8 + n, (64'(cb(a, 1'b1)) << n) | ((64'h1 << n) - 64'h1), rx);
    endtask : rd
    task automatic stop_test;
        if (err_count == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test
    // ****
    // scenarios
    // ****
    task automatic t_write;
        rd(1'b1, 5'h09, 48);
        chk(rx[47:0], {24'ha10000, 24'h0});
        wr(1'b1, cb(5'h0a, 1'b0), 48, {24'h123456, 24'habcdef});
        chk(rx[55:0], {56{1'bz}});
        rd(1'b0, 5'h0a, 48);
        chk(rx[47:0], {24'h123456, 24'habcdef});
        wr(1'b0, cb(5'h1f, 1'b0), 48, {24'ha50000, 24'h222222});
        rd(1'b0, 5'h08, 24);
        chk(rx[23:0], 24'h222222);
    endtask : t_write
    task automatic t_ready_ro;
        @(negedge clk_in);
        ch_data_in.res[0] = 24'h111111;
        ch_data_in.res[2] = 24'h333333;
        ch_valid_in = 1'b1;
        @(negedge clk_in);
        chk(conversion_ready_n_out, 1'b0);
        ch_valid_in = 1'b0;
        @(negedge clk_in);
        chk(conversion_ready_n_out, 1'b1);
        wr(1'b0, cb(5'h02, 1'b0), 24, 24'h777777);
        rd(1'b1, 5'h02, 24);
        chk(rx[23:0], 24'h333333);
    endtask : t_ready_ro
    // every read loop mode, first word then its successor
    task automatic t_loops;
        logic [4:0]  la[4] = '{5'h0b, 5'h0b, 5'h07, 5'h07};
        logic [47:0] le[4] = '{48'habcdefabcdef, 48'habcdef222222, 48'h111111, 48'h222222};
        for (int m = 0; m < 4; m++) begin
            wr(1'b0, cb(5'h09, 1'b0), 24, {2'(m), 22'h210000});
            rd(1'b0, la[m], 48);
            chk(rx[47:0], le[m]);
        end
        // static write loop keeps the address
        wr(1'b0, cb(5'h09, 1'b0), 24, 24'h010000);
        wr(1'b0, cb(5'h10, 1'b0), 48, {24'h444444, 24'h666666});
        rd(1'b0, 5'h10, 24);
        chk(rx[23:0], 24'h666666);
        wr(1'b0, cb(5'h09, 1'b0), 24, 24'ha10000);
    endtask : t_loops
    task automatic t_width;
        wr(1'b0, cb(5'h09, 1'b0), 24, 24'ha00000);
        wr(1'b0, cb(5'h0d, 1'b0), 16, 16'hbeef);
        rd(1'b0, 5'h0d, 16);
        chk(rx[15:0], 16'hbeef);
        wr(1'b0, cb(5'h09, 1'b0), 16, 16'ha200);
        rd(1'b1, 5'h0d, 32);
        chk(rx[31:0], 32'hbeef0000);
        wr(1'b1, cb(5'h09, 1'b0), 32, 32'ha1000000);
    endtask : t_width
    task automatic t_crc;
        c0 = config_crc_out;
        wr(1'b1, cb(5'h09, 1'b0), 24, 24'h218000);
        rd(1'b1, 5'h0d, 40);
        chk(rx[39:0], {24'hbeef00, crc16(24'hbeef00)});
        repeat (60) @(negedge clk_in);
        chk(config_crc_out !== c0, 1'b1);
        // alert enable: the config change holds the ready pin low
        wr(1'b1, cb(5'h09, 1'b0), 24, 24'ha14000);
        repeat (60) @(negedge clk_in);
        chk(conversion_ready_n_out, 1'b0);
        wr(1'b1, cb(5'h09, 1'b0), 24, 24'ha10000);
        repeat (6) @(negedge clk_in);
        chk(conversion_ready_n_out, 1'b1);
    endtask : t_crc
    task automatic t_lock;
        wr(1'b1, cb(5'h1f, 1'b0), 24, 24'h000000);
        wr(1'b1, cb(5'h0c, 1'b0), 24, 24'h555555);
        rd(1'b1, 5'h0c, 24);
        chk(rx[23:0], 24'h0);
        wr(1'b0, cb(5'h1f, 1'b0), 24, 24'ha50000);
        wr(1'b0, cb(5'h0c, 1'b0), 24, 24'h555555);
        rd(1'b0, 5'h0c, 24);
        chk(rx[23:0], 24'h555555);
    endtask : t_lock
    task automatic t_abort;
        @(negedge clk_in);
        host.xfer(1'b0, 28, (64'(cb(5'h0e, 1'b0)) << 20) | 64'h12345, rx);
        wr(1'b1, {2'b10, 5'h0e, 1'b0}, 24, 24'h999999);
        @(negedge clk_in);
        host.xfer(1'b1, 32, 64'({2'b10, 5'h0e, 1'b1}) << 24, rx);
        chk(rx[23:0], {24{1'bz}});
        rd(1'b0, 5'h0e, 24);
        chk(rx[23:0], 24'h0);
        @(negedge clk_in);
        rst_in = 1'b1;
        repeat (4) @(negedge clk_in);
        rst_in = 1'b0;
        repeat (4) @(negedge clk_in);
        rd(1'b0, 5'h0a, 24);
        chk(rx[23:0], 24'h0);
    endtask : t_abort
    // main sequence after a four-cycle reset
    initial begin
        // raised after time zero so the asynchronous resets see an edge
        #1 rst_in = 1'b1;
        repeat (4) @(negedge clk_in);
        rst_in = 1'b0;
        repeat (4) @(negedge clk_in);
        t_write();
        t_ready_ro();
        t_loops();
        t_width();
        t_crc();
        t_lock();
        t_abort();
        stop_test();
    end
    // watchdog against a hang
    initial begin
        repeat (60000) @(posedge clk_in);
        err_count++;
        stop_test();
    end
endmodule : afe_spi_register_port_tb_top
bind afe_spi_register_port afe_spi_register_port_checker #(.CHIP_ID(CHIP_ID)) chk_i (
    .clk_in(clk_in), .rst_in(rst_in), .sck_in(sck_in), .cs_n_in(cs_n_in), .sdi_in(sdi_in),
    .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out), .ch_data_in(ch_data_in),
    .ch_valid_in(ch_valid_in), .conversion_ready_n_out(conversion_ready_n_out),
    .config_crc_out(config_crc_out));
`default_nettype wire

// [verif/spi_host_model.sv]
// host controller model driving the serial link
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
    output logic      sck_out,
    output logic      cs_n_out,
    output logic      sdi_out,
    input  wire logic sdo_in,
    input  wire logic sdo_oe_in
);
    // link clock stands still between frames
    // idle levels come after reset rises, so the frame reset sees a clean edge
    initial begin
        #2;
        sck_out = 1'b0;
        cs_n_out = 1'b1;
        sdi_out = 1'b0;
    end
    // ****
    // one framed transfer, msb first, 80 ns clock
    // ****
    // idle level set while deselected
    task automatic xfer(input logic cpol, input int n, input logic [63:0] tx,
                        output logic [63:0] rx);
        rx = 64'h0;
        // keep clear of a deselect that ends the previous frame
        #10 sck_out = cpol;
        #40;
        cs_n_out = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            #40 sck_out = 1'b0;
            sdi_out = tx[i];
            // sample on rising; undriven line reads z
            #40 sck_out = 1'b1;
            rx = {rx[62:0], sdo_oe_in ? sdo_in : 1'bz};
        end
        #40 sck_out = cpol;
        #40 cs_n_out = 1'b1;
        // released line must not look like data
        sdi_out = ~sdi_out;
    endtask : xfer
endmodule : spi_host_model
`default_nettype wire
